// [rtl/cfgcs_pkg.sv]
// cfgcs_pkg: constants shared by the config table command store.
// assumes an axi4-lite master and a host that feeds decoded terminal
// characters and table words through the command registers.
package cfgcs_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CHAR = 8'h08;
  localparam logic [7:0] ADDR_LIVE = 8'h0c;
  localparam logic [7:0] ADDR_WIDX = 8'h10;
  localparam logic [7:0] ADDR_WDATA = 8'h14;
  localparam logic [7:0] ADDR_RDATA = 8'h18;
  localparam logic [7:0] ADDR_DIFF = 8'h1c;
  localparam logic [7:0] ADDR_BAUD = 8'h20;
  localparam logic [7:0] ADDR_STCFG = 8'h24;
  localparam logic [7:0] ADDR_MSG = 8'h28;

  // command opcodes, cmd register bits [3:0]
  localparam logic [3:0] OP_RESET = 4'h1;
  localparam logic [3:0] OP_SAVE = 4'h2;
  localparam logic [3:0] OP_COMPARE = 4'h3;
  localparam logic [3:0] OP_DISPLAY = 4'h4;
  localparam logic [3:0] OP_LOAD = 4'h5;
  localparam logic [3:0] OP_MODIFY = 4'h6;
  // modifier field, cmd bits [9:8]
  localparam int MOD_LSB = 8;
  localparam logic [1:0] STORE_DEFAULT = 2'h0;
  localparam logic [1:0] STORE_RAM = 2'h1;
  localparam logic [1:0] STORE_FACTORY = 2'h2;
  localparam logic [1:0] STORE_USER = 2'h3;
  // object selector, cmd bits [7:4]
  localparam int OBJ_LSB = 4;
  localparam logic [3:0] OBJ_ALL = 4'h0;
  localparam logic [3:0] OBJ_TABLE = 4'h1;
  localparam logic [3:0] OBJ_VIRMODE = 4'h2;
  localparam logic [3:0] OBJ_FULLFIELD = 4'h3;
  localparam logic [3:0] OBJ_TEST_LINES = 4'h4;
  localparam logic [3:0] OBJ_MATRIX = 4'h5;
  localparam logic [3:0] OBJ_TLSEQ = 4'h6;
  localparam logic [3:0] OBJ_FFSEQ = 4'h7;
  localparam logic [3:0] OBJ_SCSEQ = 4'h8;
  localparam logic [3:0] OBJ_MNEMONIC = 4'h9;
  localparam logic [3:0] OBJ_FRONT = 4'ha;
  localparam logic [3:0] OBJ_REMOTE = 4'hb;
  localparam logic [3:0] OBJ_STATUS = 4'hc;
  localparam logic [3:0] OBJ_COMMANDS = 4'hd;
  localparam logic [3:0] OBJ_BAUD = 4'he;
  localparam int NUM_TABLES = 8;
  localparam logic [3:0] TABLE_LAST = 4'h8;
  localparam logic [3:0] TABLE_FIRST = 4'h1;

  // terminal characters
  localparam logic [7:0] CH_ABORT_C = 8'h03;
  localparam logic [7:0] CH_ABORT_T = 8'h14;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_CR = 8'h0d;

  // message codes to the terminal side
  localparam logic [3:0] MSG_PROMPT = 4'h1;
  localparam logic [3:0] MSG_BUSY = 4'h2;
  localparam logic [3:0] MSG_MENU = 4'h3;
  localparam logic [3:0] MSG_DIFFS = 4'h4;
  localparam logic [3:0] MSG_MNEMONIC_EDIT = 4'h5;
  localparam logic [3:0] MSG_FRONT_EDIT = 4'h6;
  localparam logic [3:0] MSG_REMOTE_EDIT = 4'h7;
  localparam logic [3:0] MSG_MATRIX_EDIT = 4'h8;
  localparam logic [3:0] MSG_SEQ_EDIT = 4'h9;
  localparam logic [3:0] MSG_BAUD_EDIT = 4'ha;
  localparam logic [3:0] MSG_STATUS_EDIT = 4'hb;
  localparam logic [3:0] MSG_DISPLAY = 4'hc;

  // status config layout
  localparam int ST_LEVEL_LSB = 0;
  localparam int ST_BURST = 2;
  localparam int ST_TXP = 3;
  localparam int ST_PAMP = 4;
  localparam int ST_REFMODE_LSB = 5;
  localparam int ST_BYPASS = 7;
  localparam logic [1:0] LEVEL_LOW = 2'h0;
  localparam logic [1:0] LEVEL_HIGH = 2'h1;
  localparam logic [1:0] LEVEL_ALL = 2'h2;
  localparam logic [1:0] LEVEL_BOUNCE = 2'h3;
  localparam logic [1:0] REF_AUTOMATIC = 2'h0;
  localparam logic [1:0] REF_DELETE = 2'h1;
  localparam logic [1:0] REF_PASS = 2'h2;
  localparam logic [1:0] REF_INSERT = 2'h3;

  localparam logic [15:0] BAUD_RESET = 16'h0043;
  localparam int SAVE_CYCLES_DEF = 64;
endpackage : cfgcs_pkg

// [rtl/cfgcs_table_mem.sv]
// cfgcs_table_mem: one word store holding every table, one word a table.
// assumes a single clock; reads are registered one cycle.
`timescale 1ns/1ps
module cfgcs_table_mem #(
  parameter int DEPTH = 9,
  parameter int AW = 4
) (
  // clock
  input wire logic aclk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [31:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [31:0] rdata
);
  logic [31:0] mem [DEPTH];
  logic [31:0] rdata_r;

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end
  assign rdata = rdata_r;
endmodule : cfgcs_table_mem

// [rtl/cfgcs_top.sv]
// cfgcs_top: command engine moving config tables between working ram,
// the factory store and the user store, with an axi4-lite register face.
// assumes an outside uart parser writes opcodes and terminal characters.
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module cfgcs_top #(
  parameter int SAVE_CYCLES = cfgcs_pkg::SAVE_CYCLES_DEF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // live configuration
  output logic [31:0] live_cfg,
  output logic [15:0] baud_divisor,
  // message to the terminal side
  output logic [3:0] msg_code,
  output logic msg_valid
);
  typedef enum {ST_IDLE, ST_READ, ST_WRITE, ST_SAVEWAIT, ST_DONE} cfgcs_state_t;
  localparam int TW = 4;

  cfgcs_state_t state_r, state_nxt;
  logic [3:0] op_r, op_nxt, obj_r, obj_nxt, idx_r, idx_nxt, last_r, last_nxt;
  logic [1:0] src_r, src_nxt;
  logic [15:0] diff_r, diff_nxt, baud_r, baud_nxt;
  logic [31:0] live_r, live_nxt;
  logic [31:0] save_cnt_r, save_cnt_nxt;
  logic [3:0] msg_r, msg_nxt;
  logic msgv_r, msgv_nxt, ready_r, ready_nxt, query_r, query_nxt;
  logic [3:0] widx_r, widx_nxt;
  logic [31:0] rd_ram, rd_fac, rd_usr, ref_word;
  logic ram_we, usr_we;
  logic [31:0] ram_wd;
  logic [TW-1:0] ram_wa, ram_ra;
  logic wr_fire, rd_fire, cmd_wr, char_wr, wword_wr;
  logic [7:0] char_in;
  logic [1:0] req_store;

  ////////////////////////////////////////////////////////////////////////
  // three stores; factory store is fixed logic with no write port and is never written
  cfgcs_table_mem #(.DEPTH(cfgcs_pkg::NUM_TABLES + 1), .AW(TW)) u_ram (
    .aclk(aclk), .we(ram_we), .waddr(ram_wa), .wdata(ram_wd),
    .raddr(ram_ra), .rdata(rd_ram));
  cfgcs_table_mem #(.DEPTH(cfgcs_pkg::NUM_TABLES + 1), .AW(TW)) u_usr (
    .aclk(aclk), .we(usr_we), .waddr(idx_r), .wdata(rd_ram),
    .raddr(idx_r), .rdata(rd_usr));
  // factory store: fixed table contents, word = table index pattern
  always_comb begin
    rd_fac = {28'h0000000, idx_r};
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: aw and w taken together, one write outstanding
  assign awready = aresetn && awvalid && wvalid && !bvalid;
  assign wready = awready;
  assign wr_fire = awready;
  assign arready = aresetn && arvalid && !rvalid;
  assign rd_fire = arready;
  assign cmd_wr = wr_fire && awaddr == cfgcs_pkg::ADDR_CMD && wstrb[1:0] == 2'h3;
  assign char_wr = wr_fire && awaddr == cfgcs_pkg::ADDR_CHAR && wstrb[0];
  assign wword_wr = wr_fire && awaddr == cfgcs_pkg::ADDR_WDATA && wstrb == 4'hf;
  assign char_in = wdata[7:0];
  assign req_store = wdata[cfgcs_pkg::MOD_LSB +: 2];

  logic bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt, bresp_nxt;
  logic mapped_w;

  always_comb begin
    mapped_w = awaddr == cfgcs_pkg::ADDR_CMD || awaddr == cfgcs_pkg::ADDR_CHAR ||
               awaddr == cfgcs_pkg::ADDR_WIDX || awaddr == cfgcs_pkg::ADDR_WDATA ||
               awaddr == cfgcs_pkg::ADDR_BAUD || awaddr == cfgcs_pkg::ADDR_STCFG;
    bresp_nxt = bresp_r;
    if (wr_fire) begin
      bresp_nxt = mapped_w ? 2'h0 : 2'h2;
    end
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rd_fire) begin
      rresp_nxt = 2'h0;
      if (araddr == cfgcs_pkg::ADDR_STATUS) begin
        rdata_nxt = {20'h0, obj_r, 3'h0, state_r != ST_IDLE, ready_r, op_r[2:0]};
      end else if (araddr == cfgcs_pkg::ADDR_LIVE) begin
        rdata_nxt = live_r;
      end else if (araddr == cfgcs_pkg::ADDR_RDATA) begin
        rdata_nxt = rd_ram;
      end else if (araddr == cfgcs_pkg::ADDR_DIFF) begin
        rdata_nxt = {16'h0, diff_r};
      end else if (araddr == cfgcs_pkg::ADDR_BAUD) begin
        rdata_nxt = {16'h0, baud_r};
      end else if (araddr == cfgcs_pkg::ADDR_MSG) begin
        rdata_nxt = {28'h0, msg_r};
      end else if (araddr == cfgcs_pkg::ADDR_WIDX) begin
        rdata_nxt = {28'h0, widx_r};
      end else begin
        rdata_nxt = 32'h0;
        rresp_nxt = 2'h2;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h0;
    end else begin
      bvalid_r <= wr_fire || (bvalid_r && !bready);
      rvalid_r <= rd_fire || (rvalid_r && !rready);
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign bvalid = bvalid_r;
  assign rvalid = rvalid_r;
  assign bresp = bresp_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // command engine
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    obj_nxt = obj_r;
    src_nxt = src_r;
    idx_nxt = idx_r;
    last_nxt = last_r;
    diff_nxt = diff_r;
    live_nxt = live_r;
    baud_nxt = baud_r;
    save_cnt_nxt = save_cnt_r;
    msg_nxt = msg_r;
    msgv_nxt = 1'b0;
    ready_nxt = ready_r;
    query_nxt = query_r;
    widx_nxt = widx_r;
    ram_we = 1'b0;
    usr_we = 1'b0;
    ram_wa = idx_r;
    ram_ra = idx_r;
    ram_wd = rd_usr;
    ref_word = src_r == cfgcs_pkg::STORE_USER ? rd_usr : rd_fac;
    if (wr_fire && awaddr == cfgcs_pkg::ADDR_WIDX) begin
      widx_nxt = wdata[3:0];
    end
    case (state_r)
      ST_IDLE: begin
        ram_ra = widx_r;
        if (wword_wr) begin
          ram_we = 1'b1;
          ram_wa = widx_r;
          ram_wd = wdata;
        end else if (wr_fire && awaddr == cfgcs_pkg::ADDR_STCFG) begin
          live_nxt = wdata;
        end else if (wr_fire && awaddr == cfgcs_pkg::ADDR_BAUD) begin
          baud_nxt = wdata[15:0];
        end
        if (char_wr) begin
          if (char_in == cfgcs_pkg::CH_QUERY) begin
            query_nxt = 1'b1;
          end else if (char_in == cfgcs_pkg::CH_CR && query_r) begin
            query_nxt = 1'b0;
            msg_nxt = cfgcs_pkg::MSG_MENU;
            msgv_nxt = 1'b1;
          end else begin
            query_nxt = 1'b0;
          end
        end
        if (cmd_wr && ready_r) begin
          op_nxt = wdata[3:0];
          obj_nxt = wdata[cfgcs_pkg::OBJ_LSB +: 4];
          ready_nxt = 1'b0;
          diff_nxt = 16'h0;
          // grouped tables: one selector per group, all walks tables 1 through 8 only
          if (wdata[cfgcs_pkg::OBJ_LSB +: 4] == cfgcs_pkg::OBJ_ALL) begin
            idx_nxt = cfgcs_pkg::TABLE_FIRST;
            last_nxt = cfgcs_pkg::TABLE_LAST;
          end else begin
            idx_nxt = wdata[cfgcs_pkg::OBJ_LSB +: 4];
            last_nxt = wdata[cfgcs_pkg::OBJ_LSB +: 4];
          end
          case (wdata[3:0])
            cfgcs_pkg::OP_RESET: src_nxt = cfgcs_pkg::STORE_FACTORY;
            cfgcs_pkg::OP_LOAD: src_nxt = cfgcs_pkg::STORE_USER;
            cfgcs_pkg::OP_SAVE: src_nxt = cfgcs_pkg::STORE_RAM;
            cfgcs_pkg::OP_COMPARE: begin
              src_nxt = req_store == cfgcs_pkg::STORE_USER ?
                        cfgcs_pkg::STORE_USER : cfgcs_pkg::STORE_FACTORY;
            end
            default: begin
              src_nxt = req_store == cfgcs_pkg::STORE_DEFAULT ?
                        cfgcs_pkg::STORE_RAM : req_store;
            end
          endcase
          state_nxt = wdata[3:0] == cfgcs_pkg::OP_DISPLAY ||
                      wdata[3:0] == cfgcs_pkg::OP_MODIFY ? ST_DONE : ST_READ;
          if (wdata[3:0] == cfgcs_pkg::OP_DISPLAY) begin
            msg_nxt = cfgcs_pkg::MSG_DISPLAY;
          end else if (wdata[3:0] == cfgcs_pkg::OP_MODIFY) begin
            case (wdata[cfgcs_pkg::OBJ_LSB +: 4])
              cfgcs_pkg::OBJ_MNEMONIC: msg_nxt = cfgcs_pkg::MSG_MNEMONIC_EDIT;
              cfgcs_pkg::OBJ_FRONT: msg_nxt = cfgcs_pkg::MSG_FRONT_EDIT;
              cfgcs_pkg::OBJ_REMOTE: msg_nxt = cfgcs_pkg::MSG_REMOTE_EDIT;
              cfgcs_pkg::OBJ_MATRIX: msg_nxt = cfgcs_pkg::MSG_MATRIX_EDIT;
              cfgcs_pkg::OBJ_BAUD: msg_nxt = cfgcs_pkg::MSG_BAUD_EDIT;
              cfgcs_pkg::OBJ_STATUS: msg_nxt = cfgcs_pkg::MSG_STATUS_EDIT;
              default: msg_nxt = cfgcs_pkg::MSG_SEQ_EDIT;
            endcase
          end
          msgv_nxt = (state_nxt == ST_DONE);
        end
      end
      ST_READ: begin
        // one cycle for the registered read of ram and user store
        state_nxt = ST_WRITE;
      end
      ST_WRITE: begin
        if (op_r == cfgcs_pkg::OP_RESET || op_r == cfgcs_pkg::OP_LOAD) begin
          ram_we = 1'b1;
          ram_wd = ref_word;
          // only the full-field group drives live outputs; a restored matrix
          // stays in ram, and nothing in this block copies it to live_cfg
          if (idx_r == cfgcs_pkg::OBJ_FULLFIELD) begin
            live_nxt = ref_word;
          end
        end else if (op_r == cfgcs_pkg::OP_SAVE) begin
          usr_we = 1'b1;
        end else if (ref_word != rd_ram) begin
          diff_nxt = diff_r + 16'h1;
        end
        if (idx_r == last_r) begin
          save_cnt_nxt = 32'h0;
          state_nxt = op_r == cfgcs_pkg::OP_SAVE ? ST_SAVEWAIT : ST_DONE;
          if (op_r == cfgcs_pkg::OP_COMPARE) begin
            msg_nxt = cfgcs_pkg::MSG_DIFFS;
            msgv_nxt = 1'b1;
          end
        end else begin
          idx_nxt = idx_r + 4'h1;
          state_nxt = ST_READ;
        end
      end
      ST_SAVEWAIT: begin
        // user store programming time
        save_cnt_nxt = save_cnt_r + 32'h1;
        if (save_cnt_r == 32'(SAVE_CYCLES - 1)) begin
          state_nxt = ST_DONE;
        end
      end
      default: begin
        // ST_DONE: prompt again, then the next command may come
        msg_nxt = cfgcs_pkg::MSG_PROMPT;
        msgv_nxt = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
    endcase
    // busy covers the whole save: the copy walk as well as the programming wait
    if (op_r == cfgcs_pkg::OP_SAVE && state_r != ST_IDLE && state_r != ST_DONE && char_wr &&
        char_in != cfgcs_pkg::CH_ABORT_C && char_in != cfgcs_pkg::CH_ABORT_T) begin
      msg_nxt = cfgcs_pkg::MSG_BUSY;
      msgv_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      op_r <= 4'h0;
      obj_r <= 4'h0;
      src_r <= 2'h0;
      idx_r <= 4'h0;
      last_r <= 4'h0;
      diff_r <= 16'h0;
      live_r <= 32'h0;
      baud_r <= cfgcs_pkg::BAUD_RESET;
      save_cnt_r <= 32'h0;
      msg_r <= cfgcs_pkg::MSG_PROMPT;
      msgv_r <= 1'b0;
      ready_r <= 1'b1;
      query_r <= 1'b0;
      widx_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      obj_r <= obj_nxt;
      src_r <= src_nxt;
      idx_r <= idx_nxt;
      last_r <= last_nxt;
      diff_r <= diff_nxt;
      live_r <= live_nxt;
      baud_r <= baud_nxt;
      save_cnt_r <= save_cnt_nxt;
      msg_r <= msg_nxt;
      msgv_r <= msgv_nxt;
      ready_r <= ready_nxt;
      query_r <= query_nxt;
      widx_r <= widx_nxt;
    end
  end
  assign live_cfg = live_r;
  assign baud_divisor = baud_r;
  assign msg_code = msg_r;
  assign msg_valid = msgv_r;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_prompt_pulse;
    msgv_r && msg_r == cfgcs_pkg::MSG_PROMPT;
  endsequence
  a_save_keeps_live: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_WRITE && op_r == cfgcs_pkg::OP_SAVE) |=> $stable(live_r))
    else $error("save changed live config");
  a_save_busy_reply: assert property (@(posedge aclk) disable iff (!aresetn)
    (op_r == cfgcs_pkg::OP_SAVE && state_r != ST_IDLE && state_r != ST_DONE && char_wr &&
     char_in != cfgcs_pkg::CH_ABORT_C && char_in != cfgcs_pkg::CH_ABORT_T) |=>
    (msgv_r && msg_r == cfgcs_pkg::MSG_BUSY))
    else $error("no busy during save");
  a_abort_no_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_SAVEWAIT && char_wr && char_in == cfgcs_pkg::CH_ABORT_C) |=>
    !(msgv_r && msg_r == cfgcs_pkg::MSG_BUSY))
    else $error("busy sent for abort code");
  a_done_prompt: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_DONE) |=> (msgv_r && msg_r == cfgcs_pkg::MSG_PROMPT && ready_r))
    else $error("no prompt after command");
  a_cmd_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ready_r && state_r != ST_DONE) |=> !ready_r)
    else $error("ready without prompt");
  a_reset_source: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_wr && ready_r && wdata[3:0] == cfgcs_pkg::OP_RESET) |=>
    src_r == cfgcs_pkg::STORE_FACTORY)
    else $error("reset not from factory store");
  a_compare_default: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_wr && ready_r && wdata[3:0] == cfgcs_pkg::OP_COMPARE && req_store == 2'h0) |=>
    src_r == cfgcs_pkg::STORE_FACTORY)
    else $error("compare default wrong");
  a_display_default: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_wr && ready_r && wdata[3:0] == cfgcs_pkg::OP_DISPLAY && req_store == 2'h0) |=>
    src_r == cfgcs_pkg::STORE_RAM ##1 s_prompt_pulse)
    else $error("display default wrong");
  a_menu_query: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_IDLE && query_r && char_wr && char_in == cfgcs_pkg::CH_CR && !cmd_wr) |=>
    (msgv_r && msg_r == cfgcs_pkg::MSG_MENU))
    else $error("menu not shown");
endmodule : cfgcs_top

// [dv/cfgcs_term_model.sv]
// cfgcs_term_model: operator terminal side, hears message pulses.
// assumes one clock shared with the block.
`timescale 1ns/1ps
module cfgcs_term_model (
  // clock
  input wire logic aclk,
  // from the block
  input wire logic [3:0] msg_code,
  input wire logic msg_valid,
  // to the bench
  output logic heard,
  output logic [3:0] heard_code
);
  // a save is never aborted from here, no abort code is ever sent
  always_ff @(posedge aclk) begin
    heard <= msg_valid;
    heard_code <= msg_code;
  end
endmodule : cfgcs_term_model

// [dv/config_table_command_store_tb.sv]
// config_table_command_store_tb: drives commands over axi4-lite and scores messages.
// assumes the terminal model beside the block; save wait shortened to 40.
`timescale 1ns/1ps
module config_table_command_store_tb;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ch;
  logic [31:0] wdata = 32'h0, rdata, live_cfg, rd, keep;
  logic [3:0] wstrb = 4'hf, msg_code, heard_code;
  logic awready, wready, bvalid, arready, rvalid, msg_valid, heard;
  logic [1:0] bresp, rresp, r;
  logic [15:0] baud_divisor;
  logic [3:0] exp_q[$];
  logic [3:0] mobj[9] = '{4'h9, 4'ha, 4'hb, 4'h5, 4'h6, 4'h7, 4'h8, 4'he, 4'hc};
  logic [3:0] mmsg[9] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h9, 4'h9, 4'ha, 4'hb};
  int bad_count = 0, checks = 0, seed = 32'hc9c0a8b5, v;
  cfgcs_top #(.SAVE_CYCLES(40)) dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .live_cfg(live_cfg), .baud_divisor(baud_divisor), .msg_code(msg_code),
    .msg_valid(msg_valid));
  cfgcs_term_model term_u (.aclk(aclk), .msg_code(msg_code), .msg_valid(msg_valid),
    .heard(heard), .heard_code(heard_code));
  initial forever #4 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!awready);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rdr
  // polls status; the watchdog bounds a command that never finishes
  task automatic idle();
    repeat (4) @(posedge aclk);
    do rdr(cfgcs_pkg::ADDR_STATUS); while (rd[3] !== 1'b1 || rd[4] !== 1'b0);
  endtask : idle
  task automatic cmd(input logic [3:0] op, input logic [3:0] obj, input logic [1:0] st);
    wr(cfgcs_pkg::ADDR_CMD, {22'h0, st, obj, op});
    idle();
  endtask : cmd
  task automatic ram(input logic [31:0] idx, input logic [31:0] exp);
    wr(cfgcs_pkg::ADDR_WIDX, idx);
    rdr(cfgcs_pkg::ADDR_RDATA);
    check("ram word", rd, exp);
  endtask : ram
  task automatic results();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  // every message must have been noted by the driver beforehand
  always @(posedge aclk) begin
    if (heard) begin
      if (exp_q.size() == 0) check("msg extra", {28'h0, heard_code}, 32'h0);
      else check("msg", {28'h0, heard_code}, {28'h0, exp_q.pop_front()});
    end
  end
  initial begin
    #160000;
    bad_count++;
    results();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(cfgcs_pkg::ADDR_BAUD);
    check("baud reset", rd, {16'h0, cfgcs_pkg::BAUD_RESET});
    v = $random(seed);
    wr(cfgcs_pkg::ADDR_BAUD, {16'h0, v[15:0]});
    check("baud", {16'h0, baud_divisor}, {16'h0, v[15:0]});
    rdr(8'h3c);
    check("unmapped", {r, rd[29:0]}, 32'h80000000);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(cfgcs_pkg::ADDR_STCFG, {24'h0, v[7], i[1:0], v[4:2], i[1:0]});
      check("live", live_cfg, {24'h0, v[7], i[1:0], v[4:2], i[1:0]});
    end
    for (int i = 0; i < 9; i++) begin
      exp_q.push_back(mmsg[i]);
      exp_q.push_back(cfgcs_pkg::MSG_PROMPT);
      cmd(cfgcs_pkg::OP_MODIFY, mobj[i], cfgcs_pkg::STORE_DEFAULT);
    end
    for (int s = 0; s < 4; s++) begin
      exp_q.push_back(cfgcs_pkg::MSG_DISPLAY);
      exp_q.push_back(cfgcs_pkg::MSG_PROMPT);
      cmd(cfgcs_pkg::OP_DISPLAY, s[0] ? cfgcs_pkg::OBJ_STATUS : cfgcs_pkg::OBJ_COMMANDS, s[1:0]);
    end
    exp_q.push_back(cfgcs_pkg::MSG_MENU);
    wr(cfgcs_pkg::ADDR_CHAR, {24'h0, cfgcs_pkg::CH_QUERY});
    wr(cfgcs_pkg::ADDR_CHAR, {24'h0, cfgcs_pkg::CH_CR});
    exp_q.push_back(cfgcs_pkg::MSG_PROMPT);
    cmd(cfgcs_pkg::OP_RESET, cfgcs_pkg::OBJ_ALL, cfgcs_pkg::STORE_DEFAULT);
    for (int i = 1; i < 9; i++) ram(i, i);
    // factory word of a table is its index, so the full-field group restores to it
    check("live restored", live_cfg, {28'h0, cfgcs_pkg::OBJ_FULLFIELD});
    keep = live_cfg;
    v = $random(seed);
    ch = (v[7:0] == cfgcs_pkg::CH_ABORT_C || v[7:0] == cfgcs_pkg::CH_ABORT_T) ? 8'h41 : v[7:0];
    exp_q.push_back(cfgcs_pkg::MSG_BUSY);
    exp_q.push_back(cfgcs_pkg::MSG_PROMPT);
    wr(cfgcs_pkg::ADDR_CMD,
       {22'h0, cfgcs_pkg::STORE_DEFAULT, cfgcs_pkg::OBJ_ALL, cfgcs_pkg::OP_SAVE});
    wr(cfgcs_pkg::ADDR_CHAR, {24'h0, ch});
    idle();
    check("live after save", live_cfg, keep);
    wr(cfgcs_pkg::ADDR_WIDX, 32'h3);
    wr(cfgcs_pkg::ADDR_WDATA, $random(seed) | 32'h100);
    for (int s = 0; s < 4; s = s + 1 + (s == 0)) begin
      exp_q.push_back(cfgcs_pkg::MSG_DIFFS);
      exp_q.push_back(cfgcs_pkg::MSG_PROMPT);
      cmd(cfgcs_pkg::OP_COMPARE, cfgcs_pkg::OBJ_ALL, s[1:0]);
      rdr(cfgcs_pkg::ADDR_DIFF);
      check("diffs", rd, 32'h1);
    end
    exp_q.push_back(cfgcs_pkg::MSG_PROMPT);
    cmd(cfgcs_pkg::OP_LOAD, cfgcs_pkg::OBJ_ALL, cfgcs_pkg::STORE_DEFAULT);
    ram(3, 3);
    v = $random(seed);
    wr(cfgcs_pkg::ADDR_STCFG, v);
    keep = v;
    exp_q.push_back(cfgcs_pkg::MSG_PROMPT);
    cmd(cfgcs_pkg::OP_RESET, cfgcs_pkg::OBJ_MATRIX, cfgcs_pkg::STORE_DEFAULT);
    ram(cfgcs_pkg::OBJ_MATRIX, {28'h0, cfgcs_pkg::OBJ_MATRIX});
    check("running matrix", live_cfg, keep);
    check("queue left", exp_q.size(), 32'h0);
    results();
  end
endmodule : config_table_command_store_tb
